//--- include/frc_pkg.sv
package frc_pkg;
  localparam int WORD_W = 32;
  localparam int ADDR_W = 5;
  localparam int CNT_W = 6;
  localparam int SYNC_N = 3;

  // five low address bits of a serial word pick the register
  localparam logic [ADDR_W-1:0] A_R5 = 5'h05;
  localparam logic [ADDR_W-1:0] A_MODE = 5'h0b;
  localparam logic [ADDR_W-1:0] A_CP = 5'h0c;
  localparam logic [ADDR_W-1:0] A_DIV = 5'h0d;
  localparam logic [ADDR_W-1:0] A_DEV = 5'h0e;
  localparam logic [ADDR_W-1:0] A_STEP = 5'h0f;
  localparam logic [ADDR_W-1:0] A_DLY = 5'h10;
  localparam logic [ADDR_W-1:0] A_FIXED = 5'h11;

  localparam int B_R5_EN = 29;
  localparam int B_SD_KEEP = 11;
  localparam int B_SGL_TRI = 9;
  localparam int B_MODE_LO = 7;
  localparam int B_CNT_CLR = 5;
  localparam int B_CP_LO = 17;
  localparam int B_CP_TRI = 15;
  localparam int B_LE_SYNC = 21;
  localparam int B_CDM_LO = 19;
  localparam int B_TDIV_LO = 7;
  localparam int B_TDIV_SEL_LO = 5;
  localparam int B_TRIG_INV = 31;
  localparam int B_TRIG_CLK = 30;
  localparam int B_DEV_SEL_LO = 25;
  localparam int B_OFS_LO = 21;
  localparam int B_DEV_LO = 5;
  localparam int B_STEP_SEL_LO = 25;
  localparam int B_STEP_LO = 3;
  localparam int B_TRIG_EN = 20;
  localparam int B_DLY_EN = 19;
  localparam int B_DLY_SEL_LO = 23;
  localparam int B_DLY_LO = 5;

  localparam int CP_W = 4;
  localparam int TDIV_W = 12;
  localparam int DEV_W = 16;
  localparam int OFS_W = 4;
  localparam int STEP_W = 20;
  localparam int DLY_W = 12;
  localparam int SCL_W = 31;
  localparam int SLOT_N = 4;

  localparam logic [CNT_W-1:0] BITS_FULL = 6'h20;
  localparam logic [CNT_W-1:0] BITS_MAX = 6'h3f;
  // pin order strobe, data, clock; the strobe idles high, so no false
  // strobe edge follows reset
  localparam logic [SYNC_N-1:0] PINS_IDLE = 3'h4;

  typedef enum logic [1:0] {
    RM_CONT_SAW = 2'h0,
    RM_CONT_TRI = 2'h1,
    RM_SGL_SAW = 2'h2,
    RM_SGL_BURST = 2'h3
  } frc_ramp_mode_t;

  typedef enum logic [1:0] {
    RS_IDLE = 2'h0,
    RS_DELAY = 2'h1,
    RS_RUN = 2'h3
  } frc_run_t;

  typedef struct packed {
    logic sd_keep;
    logic single_tri;
    frc_ramp_mode_t ramp_mode;
    logic counter_clear;
    logic [CP_W-1:0] cp_current;
    logic cp_tristate;
    logic le_sync;
    logic divider_mode_hi;
    logic divider_mode_lo;
    logic trig_invert;
    logic trig_clocks_ramp;
    logic trig_enable;
    logic delay_enable;
  } frc_cfg_t;

  typedef struct packed {
    logic [SLOT_N-1:0][TDIV_W-1:0] ramp_timer_divider;
    logic [SLOT_N-1:0][DEV_W-1:0] dev_word;
    logic [SLOT_N-1:0][OFS_W-1:0] dev_offset;
    logic [SLOT_N-1:0][STEP_W-1:0] step_count;
    logic [SLOT_N-1:0][DLY_W-1:0] delay_word;
  } frc_slots_t;

  localparam frc_cfg_t CFG_RST = '0;
  localparam frc_slots_t SLOTS_RST = '0;
endpackage

//--- core/frc_serial_rx.sv
module frc_serial_rx
  import frc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_sclk,
  input wire logic i_sdata,
  input wire logic i_load_strobe,
  output logic [WORD_W-1:0] o_word,
  output logic o_vld
);
  logic [SYNC_N-1:0] pins;
  logic [SYNC_N-1:0] s1_ff, s2_ff, s3_ff, lvl_ff, prev_ff;
  logic [SYNC_N-1:0] nxt_lvl;
  logic [WORD_W-1:0] sh_ff, nxt_sh, word_ff, nxt_word;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic vld_ff, nxt_vld;
  logic clk_rise, le_rise;

  assign pins = {i_load_strobe, i_sdata, i_sclk};

  // a pin level only counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < SYNC_N; g++)
    begin : g_filt
      assign nxt_lvl[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : lvl_ff[g];
    end
  endgenerate

  assign clk_rise = lvl_ff[0] & ~prev_ff[0];
  assign le_rise = lvl_ff[2] & ~prev_ff[2];

  always_comb
  begin
    nxt_sh = sh_ff;
    nxt_cnt = cnt_ff;
    nxt_word = word_ff;
    nxt_vld = 1'b0;
    if (le_rise)
    begin
      // short or long frames are dropped, old settings stay
      if (cnt_ff == BITS_FULL)
      begin
        nxt_word = sh_ff;
        nxt_vld = 1'b1;
      end
      nxt_cnt = '0;
    end
    else if (clk_rise && !lvl_ff[2])
    begin
      nxt_sh = {sh_ff[WORD_W-2:0], lvl_ff[1]};
      if (cnt_ff != BITS_MAX)
      begin
        nxt_cnt = cnt_ff + 6'h01;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s1_ff <= PINS_IDLE;
      s2_ff <= PINS_IDLE;
      s3_ff <= PINS_IDLE;
      lvl_ff <= PINS_IDLE;
      prev_ff <= PINS_IDLE;
      sh_ff <= '0;
      cnt_ff <= '0;
      word_ff <= '0;
      vld_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
      prev_ff <= lvl_ff;
      sh_ff <= nxt_sh;
      cnt_ff <= nxt_cnt;
      word_ff <= nxt_word;
      vld_ff <= nxt_vld;
    end
  end

  assign o_word = word_ff;
  assign o_vld = vld_ff;
endmodule // frc_serial_rx

//--- core/frc_ramp_regs.sv
// What this block does
// - address 01011, 01100, 01101 load ramp-mode, charge-pump, divider.
// - address 01110, 01111, 10000 load deviation, step, delay.
// - sd-keep bit 0 resets modulator on each register five write.
// - single full triangle enabled by bit 9, only with burst mode.
// - two-bit ramp mode field picks the generated waveform.
// - counter clear bit 1 holds counters in reset, 0 releases.
// - four-bit field sets charge pump current to the loop.
// - tristate bit 1 puts charge pump output high impedance.
// - le-sync bit 1 retimes the load strobe to reference input.
// - 12-bit ramp timer divider stored in the selected slot.
// - trigger invert bit picks rising or falling active edge.
// - trigger-clock bit chooses divider tick or trigger pin.
// - deviation select picks which of four deviation slots loads.
// - four-bit deviation offset scales the deviation step.
// - 16-bit deviation word is signed two's complement.
// - 20-bit step count loads into the selected step slot.
// - trigger enable lets trigger plus register five bit start ramp.
// - with trigger enable set, ramps start and stop only on a trigger after enable changes.
// - delay enable and 12-bit delay word in selected delay slot.
module frc_ramp_regs
  import frc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_sclk,
  input wire logic i_sdata,
  input wire logic i_load_strobe,
  input wire logic i_reference_input,
  input wire logic i_trigger_pin,
  input wire logic i_div_tick,
  output frc_cfg_t o_cfg,
  output frc_slots_t o_slots,
  output logic [SLOT_N-1:0][SCL_W-1:0] o_dev_step,
  output logic o_single_tri,
  output logic o_sd_reset,
  output logic o_ramp_step,
  output logic o_ramp_run
);
  logic [WORD_W-1:0] wd;
  logic wd_vld;
  logic [ADDR_W-1:0] wd_addr;

  frc_serial_rx u_rx (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_sclk(i_sclk),
    .i_sdata(i_sdata),
    .i_load_strobe(i_load_strobe),
    .o_word(wd),
    .o_vld(wd_vld)
  );

  assign wd_addr = wd[ADDR_W-1:0];

  // reference and trigger pins, bit 0 reference, bit 1 trigger
  logic [1:0] pin_in;
  logic [1:0] p1_ff, p2_ff, p3_ff, plvl_ff, pprev_ff;
  logic [1:0] nxt_plvl;
  logic ref_rise, trig_rise, trig_fall, trig_act;

  assign pin_in = {i_trigger_pin, i_reference_input};

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_pin
      assign nxt_plvl[g] = (p2_ff[g] == p3_ff[g]) ? p3_ff[g] : plvl_ff[g];
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      p1_ff <= '0;
      p2_ff <= '0;
      p3_ff <= '0;
      plvl_ff <= '0;
      pprev_ff <= '0;
    end
    else
    begin
      p1_ff <= pin_in;
      p2_ff <= p1_ff;
      p3_ff <= p2_ff;
      plvl_ff <= nxt_plvl;
      pprev_ff <= plvl_ff;
    end
  end

  assign ref_rise = plvl_ff[0] & ~pprev_ff[0];
  assign trig_rise = plvl_ff[1] & ~pprev_ff[1];
  assign trig_fall = ~plvl_ff[1] & pprev_ff[1];

  // register state
  frc_cfg_t cfg_ff, nxt_cfg;
  frc_slots_t slots_ff, nxt_slots;
  logic r5_en_ff, nxt_r5_en;
  logic pend_ff, nxt_pend;
  logic sdr_ff, nxt_sdr;
  logic commit;

  assign trig_act = cfg_ff.trig_invert ? trig_fall : trig_rise;

  // a frame waiting for the reference edge is held in the receiver word,
  // which cannot change before another 32 bits arrive
  assign commit = pend_ff & (~cfg_ff.le_sync | ref_rise);

  always_comb
  begin
    nxt_pend = (pend_ff & ~commit) | wd_vld;
    nxt_cfg = cfg_ff;
    nxt_slots = slots_ff;
    nxt_r5_en = r5_en_ff;
    nxt_sdr = 1'b0;
    if (commit)
    begin
      unique case (wd_addr)
        A_R5:
        begin
          // register five lives elsewhere, only its side effects here
          nxt_r5_en = wd[B_R5_EN];
          nxt_sdr = ~cfg_ff.sd_keep;
        end
        A_MODE:
        begin
          nxt_cfg.sd_keep = wd[B_SD_KEEP];
          nxt_cfg.single_tri = wd[B_SGL_TRI];
          nxt_cfg.ramp_mode = frc_ramp_mode_t'(wd[B_MODE_LO +: 2]);
          nxt_cfg.counter_clear = wd[B_CNT_CLR];
        end
        A_CP:
        begin
          nxt_cfg.cp_current = wd[B_CP_LO +: CP_W];
          nxt_cfg.cp_tristate = wd[B_CP_TRI];
        end
        A_DIV:
        begin
          nxt_cfg.le_sync = wd[B_LE_SYNC];
          nxt_cfg.divider_mode_hi = wd[B_CDM_LO + 1];
          nxt_cfg.divider_mode_lo = wd[B_CDM_LO];
          nxt_slots.ramp_timer_divider[wd[B_TDIV_SEL_LO +: 2]] =
            wd[B_TDIV_LO +: TDIV_W];
        end
        A_DEV:
        begin
          nxt_cfg.trig_invert = wd[B_TRIG_INV];
          nxt_cfg.trig_clocks_ramp = wd[B_TRIG_CLK];
          nxt_slots.dev_word[wd[B_DEV_SEL_LO +: 2]] =
            wd[B_DEV_LO +: DEV_W];
          nxt_slots.dev_offset[wd[B_DEV_SEL_LO +: 2]] =
            wd[B_OFS_LO +: OFS_W];
        end
        A_STEP:
        begin
          nxt_slots.step_count[wd[B_STEP_SEL_LO +: 2]] =
            wd[B_STEP_LO +: STEP_W];
        end
        A_DLY:
        begin
          nxt_cfg.trig_enable = wd[B_TRIG_EN];
          nxt_cfg.delay_enable = wd[B_DLY_EN];
          nxt_slots.delay_word[wd[B_DLY_SEL_LO +: 2]] =
            wd[B_DLY_LO +: DLY_W];
        end
        default:
        begin
          // fixed setup word and foreign registers have no state here
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cfg_ff <= CFG_RST;
      slots_ff <= SLOTS_RST;
      r5_en_ff <= 1'b0;
      pend_ff <= 1'b0;
      sdr_ff <= 1'b0;
    end
    else
    begin
      cfg_ff <= nxt_cfg;
      slots_ff <= nxt_slots;
      r5_en_ff <= nxt_r5_en;
      pend_ff <= nxt_pend;
      sdr_ff <= nxt_sdr;
    end
  end

  // deviation step per slot, sign extended then shifted by the offset
  logic [SLOT_N-1:0][SCL_W-1:0] dev_scl;
  logic [SLOT_N-1:0][SCL_W-1:0] dev_step_ff;

  generate
    for (g = 0; g < SLOT_N; g++)
    begin : g_dev
      logic signed [SCL_W-1:0] ext;
      assign ext = {{(SCL_W-DEV_W){slots_ff.dev_word[g][DEV_W-1]}},
                    slots_ff.dev_word[g]};
      assign dev_scl[g] = ext <<< slots_ff.dev_offset[g];
    end
  endgenerate

  // single triangle is only honoured in burst mode
  logic sgl_ff, nxt_sgl;
  assign nxt_sgl = cfg_ff.single_tri &
                   (cfg_ff.ramp_mode == RM_SGL_BURST);

  // ramp run control
  frc_run_t st_ff, nxt_st;
  logic [DLY_W-1:0] dcnt_ff, nxt_dcnt;
  logic step_ff, nxt_step;
  logic run_ff, nxt_run;
  logic step_src, go, stop;

  assign step_src = cfg_ff.trig_clocks_ramp ? trig_act : i_div_tick;
  assign go = cfg_ff.trig_enable ? (trig_act & r5_en_ff) : r5_en_ff;
  assign stop = cfg_ff.trig_enable ? (trig_act & ~r5_en_ff)
                                   : ~r5_en_ff;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_dcnt = dcnt_ff;
    if (cfg_ff.counter_clear)
    begin
      nxt_st = RS_IDLE;
      nxt_dcnt = '0;
    end
    else
    begin
      unique case (st_ff)
        RS_IDLE:
        begin
          if (go)
          begin
            if (cfg_ff.delay_enable)
            begin
              nxt_st = RS_DELAY;
              nxt_dcnt = slots_ff.delay_word[0];
            end
            else
            begin
              nxt_st = RS_RUN;
            end
          end
        end
        RS_DELAY:
        begin
          if (stop)
          begin
            nxt_st = RS_IDLE;
          end
          else if (dcnt_ff == '0)
          begin
            nxt_st = RS_RUN;
          end
          else if (step_src)
          begin
            nxt_dcnt = dcnt_ff - 12'h001;
          end
        end
        RS_RUN:
        begin
          if (stop)
          begin
            nxt_st = RS_IDLE;
          end
        end
        default:
        begin
          nxt_st = RS_IDLE;
        end
      endcase
    end
    nxt_step = (st_ff == RS_RUN) & step_src & ~cfg_ff.counter_clear;
    nxt_run = (nxt_st == RS_RUN);
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_ff <= RS_IDLE;
      dcnt_ff <= '0;
      step_ff <= 1'b0;
      run_ff <= 1'b0;
      sgl_ff <= 1'b0;
      dev_step_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
      dcnt_ff <= nxt_dcnt;
      step_ff <= nxt_step;
      run_ff <= nxt_run;
      sgl_ff <= nxt_sgl;
      dev_step_ff <= dev_scl;
    end
  end

  assign o_cfg = cfg_ff;
  assign o_slots = slots_ff;
  assign o_dev_step = dev_step_ff;
  assign o_single_tri = sgl_ff;
  assign o_sd_reset = sdr_ff;
  assign o_ramp_step = step_ff;
  assign o_ramp_run = run_ff;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  sd_reset_fire_a: assert property (
    commit && wd_addr == A_R5 && !cfg_ff.sd_keep |=> o_sd_reset)
    else $error("modulator reset missing on register five write");

  sd_reset_keep_a: assert property (
    o_sd_reset |-> $past(commit && wd_addr == A_R5 && !cfg_ff.sd_keep))
    else $error("modulator reset without cause");

  mode_load_a: assert property (
    commit && wd_addr == A_MODE |=>
      o_cfg.ramp_mode == $past(wd[8:7]) &&
      o_cfg.counter_clear == $past(wd[5]))
    else $error("ramp mode word not loaded");

  cp_load_a: assert property (
    commit && wd_addr == A_CP |=>
      o_cfg.cp_current == $past(wd[20:17]) &&
      o_cfg.cp_tristate == $past(wd[15]))
    else $error("charge pump word not loaded");

  tdiv_slot_a: assert property (
    commit && wd_addr == A_DIV |=>
      o_slots.ramp_timer_divider[$past(wd[6:5])] == $past(wd[18:7]))
    else $error("timer divider slot wrong");

  step_slot_a: assert property (
    commit && wd_addr == A_STEP |=>
      o_slots.step_count[$past(wd[26:25])] == $past(wd[22:3]))
    else $error("step slot wrong");

  cfg_hold_a: assert property (
    !commit |=> $stable(o_cfg) && $stable(o_slots))
    else $error("settings changed without a frame");

  le_retime_a: assert property (
    pend_ff && cfg_ff.le_sync && !ref_rise |=> pend_ff)
    else $error("frame applied off the reference edge");

  step_src_a: assert property (
    o_ramp_step |-> $past(step_src) && $past(st_ff) == RS_RUN)
    else $error("ramp step from wrong source");

  trig_gate_a: assert property (
    st_ff == RS_IDLE && cfg_ff.trig_enable && !trig_act |=>
      st_ff == RS_IDLE)
    else $error("ramp started without a trigger");
endmodule // frc_ramp_regs

//--- sim/frc_host_model.sv
module frc_host_model (
  input wire logic i_clk,
  output logic o_sclk,
  output logic o_sdata,
  output logic o_load_strobe
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_load_strobe = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // msb first; only a count of 32 makes a whole word
  task automatic send(input logic [63:0] w, input int n);
    tick(1);
    o_load_strobe = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      o_sdata = w[i];
      tick(5);
      o_sclk = 1'b1;
      tick(5);
      o_sclk = 1'b0;
    end
    tick(5);
    o_load_strobe = 1'b1;
    // released line must not keep showing the last bit
    o_sdata = ~o_sdata;
  endtask
endmodule // frc_host_model

//--- sim/tb_frc_ramp_regs.sv
module tb_frc_ramp_regs
  import frc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [31:0] w;
    int sel;
    logic [31:0] exp;
  } frc_row_t;

  logic clk, nrst, ref_in, trig, div_tick, sclk, sdata, le;
  frc_cfg_t cfg;
  frc_slots_t slots;
  logic [SLOT_N-1:0][SCL_W-1:0] dev_step;
  logic single_tri, sd_reset, ramp_step, ramp_run;
  int fails = 0;
  int num_checks = 0;
  int sd_cnt = 0;
  int step_cnt = 0;
  int cyc = 0;

  frc_row_t rows[22] = '{
    '{32'h0000002b, 0, 32'h1},
    '{32'h0000000b, 0, 32'h0},
    '{32'h0000008b, 1, 32'h1},
    '{32'h0000010b, 1, 32'h2},
    '{32'h0000038b, 2, 32'h1},
    '{32'h0000028b, 2, 32'h0},
    '{32'h0000080b, 3, 32'h1},
    '{32'h0000000b, 1, 32'h0},
    '{32'h004f000c, 4, 32'h7},
    '{32'h0000800c, 5, 32'h1},
    '{32'h00180a0d, 6, 32'h14},
    '{32'h001fffed, 7, 32'hfff},
    '{32'h0038000d, 8, 32'h7},
    '{32'h0000000d, 8, 32'h0},
    '{{5'h0, 2'd1, 4'd9, 16'hf8e4, 5'h0e}, 9,
      {12'h0, 4'd9, 16'hf8e4}},
    '{{5'h0, 2'd1, 4'd9, 16'hf8e4, 5'h0e}, 10,
      {1'b0, 31'h7ffff8e4 << 9}},
    '{{2'b11, 3'h0, 2'd0, 4'd0, 16'h0, 5'h0e}, 11, 32'h3},
    '{32'h0000000e, 11, 32'h0},
    '{{5'h0, 2'd2, 2'b0, 20'habcd1, 3'h7}, 12, 32'habcd1},
    '{{7'h0, 2'd1, 2'b0, 2'b11, 2'b0, 12'h5a5, 5'h10}, 13,
      32'h35a5},
    '{32'h00000010, 13, 32'h05a5},
    '{32'h00000011, 12, 32'habcd1}
  };

  frc_ramp_regs dut_u (.i_clk(clk), .i_nrst(nrst), .i_sclk(sclk),
    .i_sdata(sdata), .i_load_strobe(le), .i_reference_input(ref_in),
    .i_trigger_pin(trig), .i_div_tick(div_tick), .o_cfg(cfg),
    .o_slots(slots), .o_dev_step(dev_step), .o_single_tri(single_tri),
    .o_sd_reset(sd_reset), .o_ramp_step(ramp_step),
    .o_ramp_run(ramp_run));

  frc_host_model host_u (.i_clk(clk), .o_sclk(sclk), .o_sdata(sdata),
    .o_load_strobe(le));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    ref_in = 1'b0;
    #6;
    forever #80 ref_in = ~ref_in;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (sd_reset === 1'b1)
      sd_cnt++;
    if (ramp_step === 1'b1)
      step_cnt++;
    // about 40 frames of 366 cycles each, with ample margin
    if (cyc == 30000)
    begin
      fails++;
      $display("timeout after %0d cycles", cyc);
      stop_test();
    end
  end

  function automatic logic [31:0] fetch(input int s);
    case (s)
      0: return 32'(cfg.counter_clear);
      1: return 32'(cfg.ramp_mode);
      2: return 32'(single_tri);
      3: return 32'(cfg.sd_keep);
      4: return 32'(cfg.cp_current);
      5: return 32'(cfg.cp_tristate);
      6: return 32'(slots.ramp_timer_divider[0]);
      7: return 32'(slots.ramp_timer_divider[3]);
      8: return 32'({cfg.le_sync, cfg.divider_mode_hi, cfg.divider_mode_lo});
      9: return 32'({slots.dev_offset[1], slots.dev_word[1]});
      10: return 32'(dev_step[1]);
      11: return 32'({cfg.trig_invert, cfg.trig_clocks_ramp});
      12: return 32'(slots.step_count[2]);
      default: return 32'({cfg.trig_enable, cfg.delay_enable,
        slots.delay_word[1]});
    endcase
  endfunction

  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // settle covers filter, commit and one reference period
  task automatic put(input logic [31:0] w);
    host_u.send(64'(w), 32);
    repeat (40) @(posedge clk);
    #1;
  endtask

  // started on a reference rise, far wider than four detector periods
  task automatic trig_pulse();
    @(posedge ref_in);
    @(posedge clk);
    #1;
    trig = 1'b1;
    repeat (70) @(posedge clk);
    #1;
    trig = 1'b0;
    repeat (20) @(posedge clk);
    #1;
  endtask

  task automatic tick_once();
    step_cnt = 0;
    div_tick = 1'b1;
    @(posedge clk);
    #1;
    div_tick = 1'b0;
    repeat (5) @(posedge clk);
    #1;
  endtask

  task automatic stop_test();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    nrst = 1'b0;
    trig = 1'b0;
    div_tick = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    nrst = 1'b1;
    @(posedge clk);
    #1;
    check("reset cfg", 32'(CFG_RST), 32'(cfg));
    check("reset slots", 32'h0, 32'(slots !== SLOTS_RST));
    check("reset run", 32'h0, 32'({ramp_run, sd_reset, ramp_step}));
    $display("test reset done");

    foreach (rows[i])
    begin
      put(rows[i].w);
      check($sformatf("row %0d", i), rows[i].exp, fetch(rows[i].sel));
    end
    $display("test table done");

    host_u.send(64'h2b, 31);
    repeat (40) @(posedge clk);
    host_u.send(64'h2b, 33);
    repeat (40) @(posedge clk);
    #1;
    check("short or long frame", 32'h0, 32'(cfg.counter_clear));
    $display("test refused frames done");

    sd_cnt = 0;
    put(32'h00000005);
    check("sd resets", 32'h1, 32'(sd_cnt));
    put(32'h0000080b);
    sd_cnt = 0;
    put(32'h00000005);
    check("sd resets kept", 32'h0, 32'(sd_cnt));
    put(32'h0000000b);
    $display("test sd reset done");

    put(32'h00100010);
    put(32'h20000005);
    check("run before trigger", 32'h0, 32'(ramp_run));
    trig_pulse();
    check("run after trigger", 32'h1, 32'(ramp_run));
    tick_once();
    check("divider step", 32'h1, 32'(step_cnt));
    put(32'h00000005);
    check("run after disable", 32'h1, 32'(ramp_run));
    trig_pulse();
    check("run after stop", 32'h0, 32'(ramp_run));
    put(32'h20000005);
    trig_pulse();
    put(32'h0000002b);
    check("run under clear", 32'h0, 32'(ramp_run));
    tick_once();
    check("step under clear", 32'h0, 32'(step_cnt));
    put(32'h0000000b);
    $display("test trigger done");

    put(32'h00180050);
    trig_pulse();
    check("run in delay", 32'h0, 32'(ramp_run));
    tick_once();
    check("delay one left", 32'h0, 32'(ramp_run));
    check("no step in delay", 32'h0, 32'(step_cnt));
    tick_once();
    check("run after delay", 32'h1, 32'(ramp_run));
    put(32'h4000000e);
    step_cnt = 0;
    trig_pulse();
    check("trigger step", 32'h1, 32'(step_cnt));
    tick_once();
    check("divider ignored", 32'h0, 32'(step_cnt));
    $display("test delay and trigger clock done");
    stop_test();
  end
endmodule // tb_frc_ramp_regs
